/* File: spc_pkg.sv */
package spc_pkg;

// ----------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------
localparam logic [7:0] SPC_ADDR_OPT_A   = 8'h00;
localparam logic [7:0] SPC_ADDR_OPT_B   = 8'h04;
localparam logic [7:0] SPC_ADDR_PINOPT  = 8'h08;
localparam logic [7:0] SPC_ADDR_IRDMA   = 8'h0C;
localparam logic [7:0] SPC_ADDR_PINFUN  = 8'h10;
localparam logic [7:0] SPC_ADDR_IROPT   = 8'h14;
localparam logic [7:0] SPC_ADDR_FDRATE  = 8'h18;
localparam logic [7:0] SPC_ADDR_CTRL    = 8'h1C;
localparam logic [7:0] SPC_ADDR_STATUS  = 8'h20;

localparam logic [7:0] SPC_RST_OPT_A    = 8'h00;
localparam logic [7:0] SPC_RST_OPT_B    = 8'h28;
localparam logic [7:0] SPC_RST_PINOPT   = 8'h1E;
localparam logic [7:0] SPC_RST_IRDMA    = 8'h00;
localparam logic [7:0] SPC_RST_PINFUN   = 8'h00;
localparam logic [7:0] SPC_RST_IROPT    = 8'h10;
localparam logic [7:0] SPC_RST_FDRATE   = 8'h00;

// Writable masks: reserved bits ignore writes
localparam logic [7:0] SPC_MASK_IROPT   = 8'hFD;
localparam logic [7:0] SPC_MASK_FDRATE  = 8'h3F;

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
localparam int SPC_B_PULLUP_DIS = 7;
localparam int SPC_B_TX_WAIT    = 6;
localparam int SPC_B_RX_WAIT    = 5;
localparam int SPC_B_BANK_PRIO  = 4;
localparam int SPC_B_GPIO1_SEL  = 5;
localparam int SPC_B_GPIO0_SEL  = 4;
localparam int SPC_B_IR2_IDE    = 1;
localparam int SPC_B_APPEND_CRC = 4;
localparam int SPC_B_BANK_EN    = 3;
localparam int SPC_B_XTAL48     = 2;
localparam int SPC_B_PRECOMP_A  = 2;
localparam int SPC_B_PRECOMP_B  = 5;
localparam int SPC_B_SEL0_MODE  = 0;

localparam int SPC_TURN_CHARS   = 4;

// ----------------------------------------------------------------
// Types
// ----------------------------------------------------------------
typedef enum logic [3:0] {
    SPC_ROLE_IRQ,
    SPC_ROLE_RESIDE,
    SPC_ROLE_DMA_REQUEST_D,
    SPC_ROLE_DMA_ACK_D,
    SPC_ROLE_INFRARED_SELECT_0,
    SPC_ROLE_INFRARED_SELECT_1,
    SPC_ROLE_INFRARED_SELECT_2,
    SPC_ROLE_HIGH_SPEED_INFRARED_RECEIVE,
    SPC_ROLE_CS,
    SPC_ROLE_POWER_DOWN_CONTROL_IN,
    SPC_ROLE_IDBEN
} spc_role_t;

typedef enum logic [2:0] {
    SPC_RATE_NONE,
    SPC_RATE_125K,
    SPC_RATE_150K,
    SPC_RATE_250K,
    SPC_RATE_300K,
    SPC_RATE_500K,
    SPC_RATE_1M,
    SPC_RATE_2M
} spc_rate_t;

typedef struct packed {
    spc_role_t first;
    spc_role_t second;
    spc_role_t third;
    spc_role_t interrupt_input;
    spc_role_t ideBuf;
} spc_pins_t;

typedef struct packed {
    spc_rate_t mfm;
    spc_rate_t fm;
} spc_speed_t;

endpackage

/* File: spc_rate_map.sv */
`timescale 1ns/1ps
module spc_rate_map
    import spc_pkg::*;
(
    input  wire logic [1:0] driveField, // Drive rate field
    input  wire logic [1:0] rateSel,    // Data rate select
    output spc_pkg::spc_speed_t speed   // Resulting MFM/FM rates
);
    always_comb begin
        speed.mfm = SPC_RATE_NONE;
        speed.fm  = SPC_RATE_NONE;
        case (rateSel)
            2'h3: begin
                speed.mfm = SPC_RATE_1M;
            end
            2'h0: begin
                speed.mfm = SPC_RATE_500K;
                speed.fm  = SPC_RATE_250K;
            end
            2'h1: begin
                if (driveField == 2'h1) begin
                    speed.mfm = SPC_RATE_500K;
                    speed.fm  = SPC_RATE_250K;
                end else if (driveField == 2'h2) begin
                    speed.mfm = SPC_RATE_2M;
                end else begin
                    speed.mfm = SPC_RATE_300K;
                    speed.fm  = SPC_RATE_150K;
                end
            end
            default: begin
                speed.mfm = SPC_RATE_250K;
                speed.fm  = SPC_RATE_125K;
            end
        endcase
    end
endmodule // spc_rate_map

/* File: spc_config.sv */
`timescale 1ns/1ps
module spc_config
    import spc_pkg::*;
(
    input  wire logic        clk,          // 40 MHz clock
    input  wire logic        nrst,         // Async reset, active low
    input  wire logic        psel,         // APB select
    input  wire logic        penable,      // APB enable
    input  wire logic        pwrite,       // APB direction
    input  wire logic [7:0]  paddr,        // APB byte address
    input  wire logic [31:0] pwdata,       // APB write data
    output logic [31:0]      prdata,       // APB read data
    output logic             pready,       // APB ready
    output logic             pslverr,      // APB error
    input  wire logic        gameStrap,    // Game-or-DMA strap pin
    input  wire logic [1:0]  rateSel,      // Floppy data rate select
    input  wire logic        bankSel0Mode, // UART B bank 7 reg 7 bit 5
    output logic             gameMode,     // Shared pins are game port
    output logic             pullupDisN,   // Parallel pull-up disable, low active
    output logic             txWait,       // Wait before transmit
    output logic             rxWait,       // Wait before receive
    output logic             bankPrio,     // Bank infrared selection wins
    output logic             irqAIsGpio,   // First interrupt pin is GPIO 1
    output logic             irqBIsGpio,   // Second interrupt pin is GPIO 0
    output logic             ir2OnIde,     // IDE select pair carries infrared 2
    output logic [2:0]       firTxDma,     // Transmit DMA channel number: 0 none, 1..4
    output logic [2:0]       firRxDma,     // Receive DMA: 0 none, 1..4
    output spc_pkg::spc_pins_t pins,       // Resolved pin roles
    output logic             appendCrc,    // Append hardware CRC
    output logic             bankEnable,   // UART B bank selection on
    output logic             xtal48,       // Crystal is 48 MHz
    output spc_pkg::spc_speed_t speedA,    // Drive A rate
    output spc_pkg::spc_speed_t speedB,    // Drive B rate
    output logic             precompOffA,  // Precompensation off drive A
    output logic             precompOffB   // Precompensation off drive B
);
    import spc_pkg::*;

    // ----------------------------------------------------------------
    // Reset and input synchronisers
    // ----------------------------------------------------------------
    logic [1:0] rstSync_reg;
    logic       rstN;
    logic [1:0] strapSync_reg;
    logic [1:0] bankSync_reg;
    logic [1:0] rateSync0_reg;
    logic [1:0] rateSync1_reg;
    logic       strapDone_reg;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) rstSync_reg <= 2'h0;
        else rstSync_reg <= {rstSync_reg[0], 1'b1};
    end
    assign rstN = rstSync_reg[1];

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            strapSync_reg <= 2'h0;
            bankSync_reg  <= 2'h0;
            rateSync0_reg <= 2'h0;
            rateSync1_reg <= 2'h0;
        end else begin
            strapSync_reg <= {strapSync_reg[0], gameStrap};
            bankSync_reg  <= {bankSync_reg[0], bankSel0Mode};
            rateSync0_reg <= rateSel;
            rateSync1_reg <= rateSync0_reg;
        end
    end

    // ----------------------------------------------------------------
    // Strap capture: once, after the synchroniser has settled
    // ----------------------------------------------------------------
    logic [1:0] strapCnt_reg;
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            strapCnt_reg  <= 2'h0;
            strapDone_reg <= 1'b0;
            gameMode      <= 1'b0;
        end else if (!strapDone_reg) begin
            strapCnt_reg <= strapCnt_reg + 2'h1;
            if (strapCnt_reg == 2'h2) begin
                strapDone_reg <= 1'b1;
                gameMode      <= strapSync_reg[1];
            end
        end
    end

    // ----------------------------------------------------------------
    // APB register file
    // ----------------------------------------------------------------
    logic [7:0] optA_reg, optB_reg, pinOpt_reg, irDma_reg;
    logic [7:0] pinFun_reg, irOpt_reg, fdRate_reg;
    wire        wrEn  = psel && penable && pwrite;
    wire        rdEn  = psel && penable && !pwrite;
    wire        hitA  = paddr == SPC_ADDR_OPT_A;
    wire        hitB  = paddr == SPC_ADDR_OPT_B;
    wire        hitP  = paddr == SPC_ADDR_PINOPT;
    wire        hitD  = paddr == SPC_ADDR_IRDMA;
    wire        hitF  = paddr == SPC_ADDR_PINFUN;
    wire        hitI  = paddr == SPC_ADDR_IROPT;
    wire        hitR  = paddr == SPC_ADDR_FDRATE;
    wire        hitS  = paddr == SPC_ADDR_STATUS;
    wire        mapped = hitA | hitB | hitP | hitD | hitF | hitI | hitR | hitS;
    wire [7:0]  wByte = pwdata[7:0];

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            optA_reg   <= SPC_RST_OPT_A;
            optB_reg   <= SPC_RST_OPT_B;
            pinOpt_reg <= SPC_RST_PINOPT;
            irDma_reg  <= SPC_RST_IRDMA;
            pinFun_reg <= SPC_RST_PINFUN;
            irOpt_reg  <= SPC_RST_IROPT;
            fdRate_reg <= SPC_RST_FDRATE;
        end else if (wrEn) begin
            if (hitA) optA_reg   <= wByte;
            if (hitB) optB_reg   <= wByte;
            if (hitP) pinOpt_reg <= wByte;
            if (hitD) irDma_reg  <= wByte;
            if (hitF) pinFun_reg <= wByte;
            if (hitI) irOpt_reg  <= wByte & SPC_MASK_IROPT;
            if (hitR) fdRate_reg <= wByte & SPC_MASK_FDRATE;
        end
    end

    // Status shows strap, bank mode and rate select as sampled
    wire [7:0] statusByte = {3'h0, strapDone_reg, rateSync1_reg, bankSync_reg[1], gameMode};
    logic [7:0] rdByte;
    always_comb begin
        rdByte = 8'h00;
        if (hitA) rdByte = optA_reg;
        if (hitB) rdByte = optB_reg;
        if (hitP) rdByte = pinOpt_reg;
        if (hitD) rdByte = irDma_reg;
        if (hitF) rdByte = pinFun_reg;
        if (hitI) rdByte = irOpt_reg;
        if (hitR) rdByte = fdRate_reg;
        if (hitS) rdByte = statusByte;
    end

    // Zero-wait slave: pready is high in every access phase
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            if (psel && !penable && !pwrite) prdata <= {24'h00_0000, rdByte};
        end
    end

    // ----------------------------------------------------------------
    // Pin role decode
    // ----------------------------------------------------------------
    function automatic spc_role_t comboRole(input logic sel0);
        comboRole = sel0 ? SPC_ROLE_INFRARED_SELECT_0 : SPC_ROLE_HIGH_SPEED_INFRARED_RECEIVE;
    endfunction

    function automatic logic [2:0] dmaChan(input logic [3:0] f);
        dmaChan = (f <= 4'h4) ? f[2:0] : 3'h0;
    endfunction

    logic sel0;
    assign sel0 = bankSync_reg[1];
    spc_pins_t pinsNext;
    always_comb begin
        case (pinFun_reg[7:6])
            2'h0: pinsNext.first = SPC_ROLE_IRQ;
            2'h1: pinsNext.first = SPC_ROLE_RESIDE;
            2'h2: pinsNext.first = SPC_ROLE_DMA_REQUEST_D;
            default: pinsNext.first = SPC_ROLE_INFRARED_SELECT_2;
        endcase
        case (pinFun_reg[5:4])
            2'h0: pinsNext.second = SPC_ROLE_CS;
            2'h1: pinsNext.second = SPC_ROLE_DMA_ACK_D;
            2'h2: pinsNext.second = SPC_ROLE_INFRARED_SELECT_1;
            default: pinsNext.second = SPC_ROLE_INFRARED_SELECT_2;
        endcase
        case (pinFun_reg[3:2])
            2'h0: pinsNext.third = SPC_ROLE_POWER_DOWN_CONTROL_IN;
            2'h1: pinsNext.third = SPC_ROLE_DMA_ACK_D;
            2'h2: pinsNext.third = SPC_ROLE_INFRARED_SELECT_1;
            default: pinsNext.third = comboRole(sel0);
        endcase
        case (pinFun_reg[1:0])
            2'h0: pinsNext.interrupt_input = SPC_ROLE_IRQ;
            2'h1: pinsNext.interrupt_input = SPC_ROLE_DMA_REQUEST_D;
            2'h2: pinsNext.interrupt_input = SPC_ROLE_INFRARED_SELECT_2;
            default: pinsNext.interrupt_input = comboRole(sel0);
        endcase
        case (irOpt_reg[7:5])
            3'h0: pinsNext.ideBuf = SPC_ROLE_IRQ;
            3'h1: pinsNext.ideBuf = SPC_ROLE_IDBEN;
            3'h2: pinsNext.ideBuf = SPC_ROLE_INFRARED_SELECT_2;
            3'h3: pinsNext.ideBuf = comboRole(sel0);
            3'h4: pinsNext.ideBuf = SPC_ROLE_DMA_ACK_D;
            default: pinsNext.ideBuf = SPC_ROLE_IRQ;
        endcase
    end

    // ----------------------------------------------------------------
    // Floppy rate decode
    // ----------------------------------------------------------------
    spc_speed_t speedANext, speedBNext;
    spc_rate_map uRateA (
        .driveField (fdRate_reg[1:0]),
        .rateSel    (rateSync1_reg),
        .speed      (speedANext)
    );
    spc_rate_map uRateB (
        .driveField (fdRate_reg[4:3]),
        .rateSel    (rateSync1_reg),
        .speed      (speedBNext)
    );

    // ----------------------------------------------------------------
    // Registered outputs
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            pullupDisN  <= 1'b1;
            txWait      <= 1'b0;
            rxWait      <= 1'b0;
            bankPrio    <= 1'b0;
            irqAIsGpio  <= 1'b0;
            irqBIsGpio  <= 1'b0;
            ir2OnIde    <= 1'b0;
            firTxDma    <= 3'h0;
            firRxDma    <= 3'h0;
            pins        <= '{SPC_ROLE_IRQ, SPC_ROLE_CS, SPC_ROLE_POWER_DOWN_CONTROL_IN, SPC_ROLE_IRQ, SPC_ROLE_IRQ};
            appendCrc   <= 1'b0;
            bankEnable  <= 1'b0;
            xtal48      <= 1'b0;
            speedA      <= '{SPC_RATE_NONE, SPC_RATE_NONE};
            speedB      <= '{SPC_RATE_NONE, SPC_RATE_NONE};
            precompOffA <= 1'b0;
            precompOffB <= 1'b0;
        end else begin
            pullupDisN  <= !optA_reg[SPC_B_PULLUP_DIS];
            txWait      <= optA_reg[SPC_B_TX_WAIT];
            rxWait      <= optA_reg[SPC_B_RX_WAIT];
            bankPrio    <= optB_reg[SPC_B_BANK_PRIO];
            irqAIsGpio  <= pinOpt_reg[SPC_B_GPIO1_SEL];
            irqBIsGpio  <= pinOpt_reg[SPC_B_GPIO0_SEL];
            ir2OnIde    <= pinOpt_reg[SPC_B_IR2_IDE];
            firTxDma    <= dmaChan(irDma_reg[7:4]);
            firRxDma    <= dmaChan(irDma_reg[3:0]);
            pins        <= pinsNext;
            appendCrc   <= irOpt_reg[SPC_B_APPEND_CRC];
            bankEnable  <= irOpt_reg[SPC_B_BANK_EN];
            xtal48      <= irOpt_reg[SPC_B_XTAL48];
            speedA      <= speedANext;
            speedB      <= speedBNext;
            precompOffA <= fdRate_reg[SPC_B_PRECOMP_A];
            precompOffB <= fdRate_reg[SPC_B_PRECOMP_B];
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    a_strap_once: assert property (@(posedge clk) disable iff (!rstN)
        strapDone_reg |=> $stable(gameMode)) else $error("strap result changed");
    a_pullup_follow: assert property (@(posedge clk) disable iff (!rstN)
        (wrEn && hitA) |=> ##1 (pullupDisN == !$past(pwdata[7], 2))) else $error("pull-up mismatch");
    a_tx_wait: assert property (@(posedge clk) disable iff (!rstN)
        (wrEn && hitA) |=> ##1 (txWait == $past(pwdata[6], 2))) else $error("tx wait mismatch");
    a_rx_wait: assert property (@(posedge clk) disable iff (!rstN)
        (wrEn && hitA) |=> ##1 (rxWait == $past(pwdata[5], 2))) else $error("rx wait mismatch");
    a_dma_range: assert property (@(posedge clk) disable iff (!rstN)
        firTxDma <= 3'h4 && firRxDma <= 3'h4) else $error("dma channel out of range");
    a_reserved_zero: assert property (@(posedge clk) disable iff (!rstN)
        fdRate_reg[7:6] == 2'h0 && irOpt_reg[1] == 1'b0) else $error("reserved bit set");
    a_combo_role: assert property (@(posedge clk) disable iff (!rstN)
        (pinFun_reg[3:2] == 2'h3) |=> (pins.third == ($past(sel0) ? SPC_ROLE_INFRARED_SELECT_0 : SPC_ROLE_HIGH_SPEED_INFRARED_RECEIVE)))
        else $error("combo role wrong");
    a_crc_follow: assert property (@(posedge clk) disable iff (!rstN)
        $past(rstN) |-> appendCrc == $past(irOpt_reg[SPC_B_APPEND_CRC])) else $error("crc flag mismatch");
    a_two_meg: assert property (@(posedge clk) disable iff (!rstN)
        (fdRate_reg[1:0] == 2'h2 && rateSync1_reg == 2'h1) |=> (speedA.mfm == SPC_RATE_2M))
        else $error("2M rate missing");
    a_ready_once: assert property (@(posedge clk) disable iff (!rstN)
        pready |=> !pready) else $error("ready held");

    // ----------------------------------------------------------------
    // Register-to-output follow-through
    // ----------------------------------------------------------------
    // The first edge after release still shows reset outputs, so it is skipped
    a_bank_prio: assert property (@(posedge clk) disable iff (!rstN)
        $past(rstN) |-> bankPrio == $past(optB_reg[SPC_B_BANK_PRIO]))
        else $error("bank priority mismatch");

    a_irq_a_gpio: assert property (@(posedge clk) disable iff (!rstN)
        $past(rstN) |-> irqAIsGpio == $past(pinOpt_reg[SPC_B_GPIO1_SEL]))
        else $error("first interrupt pin role mismatch");

    a_irq_b_gpio: assert property (@(posedge clk) disable iff (!rstN)
        $past(rstN) |-> irqBIsGpio == $past(pinOpt_reg[SPC_B_GPIO0_SEL]))
        else $error("second interrupt pin role mismatch");

    a_ide_pair: assert property (@(posedge clk) disable iff (!rstN)
        $past(rstN) |-> ir2OnIde == $past(pinOpt_reg[SPC_B_IR2_IDE]))
        else $error("ide pair role mismatch");

    a_first_role: assert property (@(posedge clk) disable iff (!rstN)
        (pinFun_reg[7:6] == 2'h2) |=> (pins.first == SPC_ROLE_DMA_REQUEST_D))
        else $error("first pin role mismatch");

    a_second_role: assert property (@(posedge clk) disable iff (!rstN)
        (pinFun_reg[5:4] == 2'h1) |=> (pins.second == SPC_ROLE_DMA_ACK_D))
        else $error("second pin role mismatch");

    a_irq_in_role: assert property (@(posedge clk) disable iff (!rstN)
        (pinFun_reg[1:0] == 2'h2) |=> (pins.interrupt_input == SPC_ROLE_INFRARED_SELECT_2))
        else $error("interrupt input pin role mismatch");

    a_ide_buf_role: assert property (@(posedge clk) disable iff (!rstN)
        (irOpt_reg[7:5] == 3'h4) |=> (pins.ideBuf == SPC_ROLE_DMA_ACK_D))
        else $error("ide buffer pin role mismatch");

    a_ide_buf_rsvd: assert property (@(posedge clk) disable iff (!rstN)
        (irOpt_reg[7:5] > 3'h4) |=> (pins.ideBuf == SPC_ROLE_IRQ))
        else $error("unlisted ide buffer code not default");

    a_bank_enable: assert property (@(posedge clk) disable iff (!rstN)
        $past(rstN) |-> bankEnable == $past(irOpt_reg[SPC_B_BANK_EN]))
        else $error("bank enable mismatch");

    a_xtal_sel: assert property (@(posedge clk) disable iff (!rstN)
        $past(rstN) |-> xtal48 == $past(irOpt_reg[SPC_B_XTAL48]))
        else $error("crystal select mismatch");

    a_precomp_off: assert property (@(posedge clk) disable iff (!rstN)
        $past(rstN) |-> (precompOffA == $past(fdRate_reg[SPC_B_PRECOMP_A]) &&
            precompOffB == $past(fdRate_reg[SPC_B_PRECOMP_B]))) else $error("precompensation mismatch");

    c_write_a:   cover property (@(posedge clk) wrEn && hitA);
    c_read_stat: cover property (@(posedge clk) rdEn && hitS);
    c_bad_addr:  cover property (@(posedge clk) pslverr);
    c_two_meg:   cover property (@(posedge clk) speedB.mfm == SPC_RATE_2M);
    c_combo_sel0: cover property (@(posedge clk) pins.third == SPC_ROLE_INFRARED_SELECT_0);
endmodule // spc_config

/* File: testbench.sv */
`timescale 1ns/1ps
module testbench;
    import spc_pkg::*;
    // ----------------------------------------------------------------
    // Signals and reference tables
    // ----------------------------------------------------------------
    logic        clk, nrst, psel, penable, pwrite, pready, pslverr, err;
    logic        gameStrap, bankSel0Mode, gameMode, pullupDisN, txWait, rxWait;
    logic        bankPrio, irqAIsGpio, irqBIsGpio, ir2OnIde, appendCrc;
    logic        bankEnable, xtal48, precompOffA, precompOffB;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0]  rateSel;
    logic [2:0]  firTxDma, firRxDma;
    spc_pins_t   pins;
    spc_speed_t  speedA, speedB;
    int          errCount, checked, seed, regModel [7];
    localparam logic [7:0] ADDR [7] = '{SPC_ADDR_OPT_A, SPC_ADDR_OPT_B, SPC_ADDR_PINOPT,
        SPC_ADDR_IRDMA, SPC_ADDR_PINFUN, SPC_ADDR_IROPT, SPC_ADDR_FDRATE};
    localparam logic [7:0] MASK [7] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFD, 8'h3F};
    localparam logic [7:0] RST [7] = '{8'h00, 8'h28, 8'h1E, 8'h00, 8'h00, 8'h10, 8'h00};
    // Entries that stand for the combined receive/select-0 role are patched in checkAll
    localparam spc_role_t ROLE1 [4] = '{SPC_ROLE_IRQ, SPC_ROLE_RESIDE, SPC_ROLE_DMA_REQUEST_D, SPC_ROLE_INFRARED_SELECT_2};
    localparam spc_role_t ROLE2 [4] = '{SPC_ROLE_CS, SPC_ROLE_DMA_ACK_D, SPC_ROLE_INFRARED_SELECT_1, SPC_ROLE_INFRARED_SELECT_2};
    localparam spc_role_t ROLE3 [4] = '{SPC_ROLE_POWER_DOWN_CONTROL_IN, SPC_ROLE_DMA_ACK_D, SPC_ROLE_INFRARED_SELECT_1, SPC_ROLE_IRQ};
    localparam spc_role_t ROLE4 [4] = '{SPC_ROLE_IRQ, SPC_ROLE_DMA_REQUEST_D, SPC_ROLE_INFRARED_SELECT_2, SPC_ROLE_IRQ};
    localparam spc_role_t ROLE5 [8] = '{SPC_ROLE_IRQ, SPC_ROLE_IDBEN, SPC_ROLE_INFRARED_SELECT_2, SPC_ROLE_IRQ,
        SPC_ROLE_DMA_ACK_D, SPC_ROLE_IRQ, SPC_ROLE_IRQ, SPC_ROLE_IRQ};

    spc_config dut (.clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .gameStrap, .rateSel, .bankSel0Mode, .gameMode, .pullupDisN, .txWait, .rxWait,
        .bankPrio, .irqAIsGpio, .irqBIsGpio, .ir2OnIde, .firTxDma, .firRxDma, .pins, .appendCrc,
        .bankEnable, .xtal48, .speedA, .speedB, .precompOffA, .precompOffB);

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // ----------------------------------------------------------------
    // Tasks and model
    // ----------------------------------------------------------------
    task automatic results();
        $display("errors %0d checks %0d", errCount, checked);
        if (errCount == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chkVal(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            errCount++;
            $display("unexpected %s: expected %0h seen %0h", nm, e, g);
        end
    endtask

    task automatic chkRole(input string nm, input spc_role_t e, input spc_role_t g);
        checked++;
        if (g !== e) begin
            errCount++;
            $display("unexpected %s: expected %0d seen %0d", nm, e, g);
        end
    endtask

    task automatic chkSpeed(input string nm, input spc_speed_t e, input spc_speed_t g);
        checked++;
        if (g !== e) begin
            errCount++;
            $display("unexpected %s: expected %0h seen %0h", nm, e, g);
        end
    endtask

    // Request held from setup until pready is sampled high
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            errCount++;
            results();
        end
    endtask

    task automatic wr(input int i, input int d);
        apb(ADDR[i], 1'b1, d);
        regModel[i] = d & MASK[i];
    endtask

    task automatic rdChk(input int i);
        apb(ADDR[i], 1'b0, $random(seed));
        chkVal("register", regModel[i], rd);
        chkVal("pslverr", 0, err);
    endtask

    function automatic int dma(input int f);
        return f <= 4 ? f : 0;
    endfunction

    function automatic spc_speed_t rate(input int f, input int s);
        if (s == 3) return '{SPC_RATE_1M, SPC_RATE_NONE};
        if (s == 0) return '{SPC_RATE_500K, SPC_RATE_250K};
        if (s == 2) return '{SPC_RATE_250K, SPC_RATE_125K};
        if (f == 1) return '{SPC_RATE_500K, SPC_RATE_250K};
        if (f == 2) return '{SPC_RATE_2M, SPC_RATE_NONE};
        return '{SPC_RATE_300K, SPC_RATE_150K};
    endfunction

    // Synchronisers on rateSel and bankSel0Mode need the longest wait
    task automatic checkAll();
        spc_role_t h;
        int a, b, q, d, p, r, f;
        repeat (6) @(posedge clk);
        a = regModel[0];
        b = regModel[1];
        q = regModel[2];
        d = regModel[3];
        p = regModel[4];
        r = regModel[5];
        f = regModel[6];
        h = bankSel0Mode ? SPC_ROLE_INFRARED_SELECT_0 : SPC_ROLE_HIGH_SPEED_INFRARED_RECEIVE;
        chkVal("pullupDisN", !a[7], pullupDisN);
        chkVal("txWait", a[6], txWait);
        chkVal("rxWait", a[5], rxWait);
        chkVal("bankPrio", b[4], bankPrio);
        chkVal("irqAIsGpio", q[5], irqAIsGpio);
        chkVal("irqBIsGpio", q[4], irqBIsGpio);
        chkVal("ir2OnIde", q[1], ir2OnIde);
        chkVal("firTxDma", dma(d[7:4]), firTxDma);
        chkVal("firRxDma", dma(d[3:0]), firRxDma);
        chkRole("first", ROLE1[p[7:6]], pins.first);
        chkRole("second", ROLE2[p[5:4]], pins.second);
        chkRole("third", p[3:2] == 3 ? h : ROLE3[p[3:2]], pins.third);
        chkRole("interrupt_input", p[1:0] == 3 ? h : ROLE4[p[1:0]], pins.interrupt_input);
        chkRole("ideBuf", r[7:5] == 3 ? h : ROLE5[r[7:5]], pins.ideBuf);
        chkVal("appendCrc", r[4], appendCrc);
        chkVal("bankEnable", r[3], bankEnable);
        chkVal("xtal48", r[2], xtal48);
        chkVal("precompOffA", f[2], precompOffA);
        chkVal("precompOffB", f[5], precompOffB);
        if (f[1:0] != 3) chkSpeed("speedA", rate(f[1:0], rateSel), speedA);
        if (f[4:3] != 3) chkSpeed("speedB", rate(f[4:3], rateSel), speedB);
    endtask

    // ----------------------------------------------------------------
    // Sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (90000) @(posedge clk);
        errCount++;
        results();
    end

    initial begin
        seed = 65;
        nrst = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {gameStrap, rateSel, bankSel0Mode} = 4'h8;
        for (int s = 1; s >= 0; s--) begin
            @(posedge clk);
            nrst <= 1'b0;
            gameStrap <= s[0];
            repeat (10) @(posedge clk);
            nrst <= 1'b1;
            repeat (3) @(posedge clk);
            // Flipping the strap once it is in the synchroniser, before capture completes, must not move the mode
            gameStrap <= !s[0];
            regModel = '{RST[0], RST[1], RST[2], RST[3], RST[4], RST[5], RST[6]};
            for (int i = 0; i < 7; i++) rdChk(i);
            checkAll();
            chkVal("gameMode", s[0], gameMode);
            apb(SPC_ADDR_STATUS, 1'b0, 0);
            chkVal("status", {1'b1, rateSel, bankSel0Mode, s[0]}, rd[4:0]);
            for (int c = 0; c < 16; c++) begin
                bankSel0Mode <= c[3];
                wr(4, 85 * c[1:0]);
                wr(5, {c[2:0], 5'h00} | ($random(seed) & 8'h1F));
                checkAll();
            end
            for (int c = 0; c < 16; c++) begin
                rateSel <= c[1:0];
                wr(3, c * 16 + 15 - c);
                wr(6, 9 * c[3:2] | ($random(seed) & 8'hE4));
                checkAll();
            end
            for (int k = 0; k < 30; k++) begin
                int i;
                i = $unsigned($random(seed)) % 7;
                wr(i, $random(seed));
                rateSel <= $random(seed);
                bankSel0Mode <= $random(seed);
                rdChk(i);
                checkAll();
            end
            apb(8'h1C, 1'b1, 32'hFF);
            chkVal("pslverr", 1, err);
            apb(8'h1C, 1'b0, 0);
            chkVal("unmapped", 0, rd);
            for (int i = 0; i < 7; i++) rdChk(i);
        end
        results();
    end
endmodule // testbench
